// *** inc/mbs_defs.svh ***
/*
  Constants for the memory board bus slave and its host end.
  Assumes inclusion by bare name from files under hw/ and inc/.
*/
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH

// Clock rates and the board clock divider
`define MBS_CORE_CLK_HZ 250000000
`define MBS_BOARD_CLK_HZ 20000000
`define MBS_BOARD_HALF_CYC 6
// Memory access latency in core cycles
`define MBS_MEM_WAIT 3
// Size line encodings, {size_b, size_a}
`define MBS_SIZE_32 2'h0
`define MBS_SIZE_8 2'h1
`define MBS_SIZE_16 2'h2
`define MBS_SIZE_24 2'h3

`endif

// *** inc/mbs_pkg.sv ***
/*
  Types used by the memory end of the memory board bus.
  Assumes mbs_defs.svh is on the include path.
*/
package mbs_pkg;
  // Acknowledge width as reported by the two ack lines
  typedef enum logic [1:0] {
    MBS_ACK_NONE = 2'h0,
    MBS_ACK_BYTE = 2'h1,
    MBS_ACK_LONG = 2'h2
  } mbs_width_e;
endpackage

// *** inc/mbs_bus_if.sv ***
/*
  Interface joining the host end and the memory board end.
  Two-way data lanes are split into in, out and enable per side;
  the testbench resolves the wire level from the enables (low drives).
*/
`timescale 1ns/1ps
interface mbs_bus_if;
  logic boardClockIn;
  logic boardResetHi;
  logic [26:0] hostAddr;
  logic addrStrobeN;
  logic readNotWrite;
  logic operandSizeA;
  logic operandSizeB;
  logic specialSpaceCycleN;
  logic progSupplyEnable;
  logic xferAckLowN;
  logic xferAckHighN;
  // Resolved data lanes, driven by the testbench
  logic [15:0] hostDataLow;
  logic [15:0] bufferedUpperData;
  // Host drive
  logic [15:0] hostDataLowHostOut;
  logic [15:0] bufferedUpperDataHostOut;
  logic hostDataOeN;
  // Memory drive
  logic [15:0] hostDataLowMemOut;
  logic [15:0] bufferedUpperDataMemOut;
  logic hostDataLowMemOeN;
  logic bufferedUpperDataMemOeN;

  modport host (
    output boardClockIn, boardResetHi, hostAddr, addrStrobeN,
    output readNotWrite, operandSizeA, operandSizeB,
    output specialSpaceCycleN, progSupplyEnable,
    output hostDataLowHostOut, bufferedUpperDataHostOut, hostDataOeN,
    input xferAckLowN, xferAckHighN, hostDataLow, bufferedUpperData
  );
  modport mem (
    input boardClockIn, boardResetHi, hostAddr, addrStrobeN,
    input readNotWrite, operandSizeA, operandSizeB,
    input specialSpaceCycleN, progSupplyEnable,
    input hostDataLow, bufferedUpperData,
    output xferAckLowN, xferAckHighN,
    output hostDataLowMemOut, bufferedUpperDataMemOut,
    output hostDataLowMemOeN, bufferedUpperDataMemOeN
  );
endinterface

// *** hw/mbs_memory_end.sv ***
/*
  Memory board end of the asynchronous processor bus: decodes a
  cycle, answers with the two acknowledge lines, buffers the upper
  lanes and gates the flash programming supply.
  Assumes bus pins arrive unsynchronised and core_clk is the local clock.
*/
// Overview of operation
// - Host holds special-space low only in such cycles
// - Special-space cycles get no decode, ack, data
// - Write: low ack only after data held
// - Read: low ack only after data taken
// - Both acks low means 32-bit transfer; here 16- and 24-bit cycles also get both acks low
// - Low ack only means byte on top lane
// - Upper 16 lanes pass a local buffer stage
// - Host raises program enable only while programming
// - Program enable switches supply onto flash pin
// - 20 MHz host clock times all logic; here core_clk times it and boardClockIn is unused
// - Reset high returns all logic to reset; here storage, the buffer stage and the synchronisers keep their values
// - Host pulses reset at power-up and power-down
// - Host pulses reset on reset instruction too
// - Strobe low starts access with valid address
// - Direction high reads, low writes, whole cycle
// - Size lines encode 8, 16, 24, 32 bits
// - Low address bits plus size give alignment
`timescale 1ns/1ps
`include "mbs_defs.svh"
module mbs_memory_end #(
  parameter int ADDR_W = 10,
  parameter int WAIT_CYC = `MBS_MEM_WAIT
) (
  input wire logic core_clk,
  input wire logic rst,
  mbs_bus_if.mem bus,
  output logic progPinSupplyOn,
  output logic [3:0] laneEnable,
  output logic [1:0] cycleWidth
);
  initial begin
    if (ADDR_W < 2 || ADDR_W > 25 || WAIT_CYC < 1 || WAIT_CYC > 255)
      $error("mbs_memory_end: unsupported parameters");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACCESS = 3'h1,
    ST_ACK = 3'h2,
    ST_RELEASE = 3'h3
  } mbs_state_e;

  // Lane enables from offset and size, top byte is lane 3
  function automatic logic [3:0] laneMask(input logic [1:0] offs,
                                          input logic [1:0] size);
    logic [2:0] count;
    logic [3:0] mask;
    count = 3'h4;
    mask = 4'h0;
    unique case (size)
      `MBS_SIZE_8: count = 3'h1;
      `MBS_SIZE_16: count = 3'h2;
      `MBS_SIZE_24: count = 3'h3;
      `MBS_SIZE_32: count = 3'h4;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (i >= offs && i < offs + count) begin
        mask[3 - i] = 1'b1;
      end
    end
    return mask;
  endfunction

  // Byte of a word picked by a one-hot lane mask
  function automatic logic [7:0] laneByte(input logic [31:0] word,
                                          input logic [3:0] mask);
    logic [7:0] pick;
    pick = 8'h00;
    for (int b = 0; b < 4; b++) begin
      if (mask[b]) begin
        pick = word[8*b +: 8];
      end
    end
    return pick;
  endfunction

  // Two-stage synchronisers on all control pins
  logic [6:0] syncA_q, syncB_q;
  logic resetPin, strobeN, rnw, sizeA, sizeB, spaceN, progEn;
  always_ff @(posedge core_clk) begin
    syncA_q <= {bus.boardResetHi, bus.addrStrobeN, bus.readNotWrite,
                bus.operandSizeA, bus.operandSizeB,
                bus.specialSpaceCycleN, bus.progSupplyEnable};
    syncB_q <= syncA_q;
  end
  assign {resetPin, strobeN, rnw, sizeA, sizeB, spaceN, progEn} = syncB_q;

  logic softRst;
  assign softRst = rst | resetPin;

  // Storage and cycle state
  logic [31:0] mem_q [2**ADDR_W];
  mbs_state_e state_q, state_d;
  logic [7:0] waitCnt_q, waitCnt_d;
  logic [31:0] rdData_q, rdData_d;
  logic [31:0] upperBuf_q;
  logic [3:0] lanes_q, lanes_d;
  logic wide_q, wide_d;
  logic rnw_q, rnw_d;
  logic [ADDR_W-1:0] word_q, word_d;
  logic ackLowN_q, ackLowN_d, ackHighN_q, ackHighN_d;
  logic prog_q;
  logic [1:0] offs;
  logic [1:0] sz;

  assign offs = bus.hostAddr[1:0];
  assign sz = {sizeB, sizeA};

  // Cycle sequencing
  always_comb begin
    state_d = state_q;
    waitCnt_d = waitCnt_q;
    rdData_d = rdData_q;
    lanes_d = lanes_q;
    wide_d = wide_q;
    rnw_d = rnw_q;
    word_d = word_q;
    ackLowN_d = ackLowN_q;
    ackHighN_d = ackHighN_q;
    unique case (state_q)
      ST_IDLE: begin
        // Address is stable once the synchronised strobe is low
        if (!strobeN && spaceN) begin
          word_d = bus.hostAddr[ADDR_W+1:2];
          rnw_d = rnw;
          lanes_d = laneMask(offs, sz);
          wide_d = (sz != `MBS_SIZE_8);
          waitCnt_d = 8'(WAIT_CYC);
          state_d = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (!spaceN) begin
          state_d = ST_IDLE;
        end else if (waitCnt_q > 8'h1) begin
          waitCnt_d = waitCnt_q - 8'h1;
        end else begin
          // Registered with the ack; a byte answer rides the top lane
          rdData_d = wide_q ? mem_q[word_q]
            : {laneByte(mem_q[word_q], lanes_q), 24'h000000};
          ackLowN_d = 1'b0;
          ackHighN_d = !wide_q;
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        if (strobeN) begin
          ackLowN_d = 1'b1;
          ackHighN_d = 1'b1;
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (softRst) begin
      state_q <= ST_IDLE;
      waitCnt_q <= 8'h00;
      rdData_q <= 32'h0000_0000;
      lanes_q <= 4'h0;
      wide_q <= 1'b0;
      rnw_q <= 1'b1;
      word_q <= '0;
      ackLowN_q <= 1'b1;
      ackHighN_q <= 1'b1;
      prog_q <= 1'b0;
    end else begin
      state_q <= state_d;
      waitCnt_q <= waitCnt_d;
      rdData_q <= rdData_d;
      lanes_q <= lanes_d;
      wide_q <= wide_d;
      rnw_q <= rnw_d;
      word_q <= word_d;
      ackLowN_q <= ackLowN_d;
      ackHighN_q <= ackHighN_d;
      prog_q <= progEn;
    end
  end

  // Local buffer stage on the upper and lower lanes
  always_ff @(posedge core_clk) begin
    upperBuf_q <= {bus.bufferedUpperData, bus.hostDataLow};
  end

  // Host write is stored as the ack goes out, data having settled
  always_ff @(posedge core_clk) begin
    if (!softRst && state_q == ST_ACCESS && state_d == ST_ACK
        && !rnw_q) begin
      for (int b = 0; b < 4; b++) begin
        if (lanes_q[b]) begin
          // Byte writes take their data from the top lane
          mem_q[word_q][8*b +: 8] <= wide_q ? upperBuf_q[8*b +: 8]
            : upperBuf_q[31:24];
        end
      end
    end
  end

  logic driveRd;
  assign driveRd = rnw_q && state_q == ST_ACK && spaceN;
  assign bus.xferAckLowN = ackLowN_q;
  assign bus.xferAckHighN = ackHighN_q;
  assign bus.hostDataLowMemOut = rdData_q[15:0];
  assign bus.bufferedUpperDataMemOut = rdData_q[31:16];
  assign bus.hostDataLowMemOeN = !(driveRd && wide_q);
  assign bus.bufferedUpperDataMemOeN = !driveRd;
  assign progPinSupplyOn = prog_q;
  assign laneEnable = lanes_q;
  assign cycleWidth = wide_q ? mbs_pkg::MBS_ACK_LONG : mbs_pkg::MBS_ACK_BYTE;
endmodule // mbs_memory_end

// *** hw/mbs_host_end.sv ***
/*
  Host end of the processor bus: makes the board clock and reset,
  runs one read or write per request and waits for acknowledge.
  Assumes a single core_clk domain; ack lines come in as pins.
*/
`timescale 1ns/1ps
`include "mbs_defs.svh"
module mbs_host_end (
  input wire logic core_clk,
  input wire logic rst,
  mbs_bus_if.host bus,
  input wire logic reqValid,
  input wire logic reqRead,
  input wire logic reqSpecial,
  input wire logic [26:0] reqAddr,
  input wire logic [1:0] reqSize,
  input wire logic [31:0] reqWrData,
  input wire logic progMode,
  input wire logic resetPulse,
  output logic reqReady,
  output logic rspValid,
  output logic [31:0] rspData,
  output logic rspByte
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_WAIT = 2'h1,
    HS_END = 2'h2
  } mbs_hstate_e;

  // Ack line synchronisers
  logic [1:0] ackA_q, ackB_q;
  always_ff @(posedge core_clk) begin
    ackA_q <= {bus.xferAckHighN, bus.xferAckLowN};
    ackB_q <= ackA_q;
  end

  mbs_hstate_e st_q, st_d;
  logic [3:0] div_q, div_d;
  logic clk_q, clk_d;
  logic strobeN_q, strobeN_d, rnw_q, rnw_d, space_q, space_d;
  logic [26:0] addr_q, addr_d;
  logic [1:0] size_q, size_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic rspV_q, rspV_d, rspB_q, rspB_d;

  // Clock divider and cycle control
  always_comb begin
    div_d = div_q + 4'h1;
    clk_d = clk_q;
    if (div_q == 4'(`MBS_BOARD_HALF_CYC - 1)) begin
      div_d = 4'h0;
      clk_d = !clk_q;
    end
    st_d = st_q;
    strobeN_d = strobeN_q;
    rnw_d = rnw_q;
    space_d = space_q;
    addr_d = addr_q;
    size_d = size_q;
    wd_d = wd_q;
    rd_d = rd_q;
    rspV_d = 1'b0;
    rspB_d = rspB_q;
    unique case (st_q)
      HS_IDLE: begin
        if (reqValid) begin
          addr_d = reqAddr;
          size_d = reqSize;
          rnw_d = reqRead;
          space_d = !reqSpecial;
          wd_d = reqWrData;
          strobeN_d = 1'b0;
          st_d = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (!ackB_q[0] || !space_q) begin
          rd_d = ackB_q[1]
            ? {24'h000000, bus.bufferedUpperData[15:8]}
            : {bus.bufferedUpperData, bus.hostDataLow};
          rspB_d = ackB_q[1];
          rspV_d = 1'b1;
          strobeN_d = 1'b1;
          st_d = HS_END;
        end
      end
      HS_END: begin
        if (ackB_q == 2'h3) begin
          space_d = 1'b1;
          st_d = HS_IDLE;
        end
      end
      default: st_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= HS_IDLE;
      div_q <= 4'h0;
      clk_q <= 1'b0;
      strobeN_q <= 1'b1;
      rnw_q <= 1'b1;
      space_q <= 1'b1;
      addr_q <= 27'h0000000;
      size_q <= `MBS_SIZE_32;
      wd_q <= 32'h0000_0000;
      rd_q <= 32'h0000_0000;
      rspV_q <= 1'b0;
      rspB_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      clk_q <= clk_d;
      strobeN_q <= strobeN_d;
      rnw_q <= rnw_d;
      space_q <= space_d;
      addr_q <= addr_d;
      size_q <= size_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      rspV_q <= rspV_d;
      rspB_q <= rspB_d;
    end
  end

  // Pins toward the memory board
  assign bus.boardClockIn = clk_q;
  assign bus.boardResetHi = rst | resetPulse;
  assign bus.hostAddr = addr_q;
  assign bus.addrStrobeN = strobeN_q;
  assign bus.readNotWrite = rnw_q;
  assign {bus.operandSizeB, bus.operandSizeA} = size_q;
  assign bus.specialSpaceCycleN = space_q;
  assign bus.progSupplyEnable = progMode & ~rst;
  assign bus.hostDataLowHostOut = wd_q[15:0];
  assign bus.bufferedUpperDataHostOut = wd_q[31:16];
  assign bus.hostDataOeN = !(st_q == HS_WAIT && !rnw_q);
  assign reqReady = (st_q == HS_IDLE);
  assign rspValid = rspV_q;
  assign rspData = rd_q;
  assign rspByte = rspB_q;
endmodule // mbs_host_end

// *** testbench/mbs_bus_props.sv ***
/*
  Concurrent checks on the bus between host end and memory end.
  Assumes one core_clk domain and the signals of mbs_bus_if.
*/
`timescale 1ns/1ps
module mbs_bus_props (
  input logic core_clk,
  input logic rst,
  input logic boardResetHi,
  input logic addrStrobeN,
  input logic readNotWrite,
  input logic operandSizeA,
  input logic operandSizeB,
  input logic specialSpaceCycleN,
  input logic xferAckLowN,
  input logic xferAckHighN,
  input logic hostDataLowMemOeN,
  input logic bufferedUpperDataMemOeN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Memory side silent: no ack, no lane drive
  sequence s_quiet;
    xferAckLowN && xferAckHighN && hostDataLowMemOeN &&
      bufferedUpperDataMemOeN;
  endsequence
  // Ack held long enough for the host to see it
  sequence s_ackStands;
    !xferAckLowN [*3];
  endsequence
  property p_spaceQuiet;
    $fell(specialSpaceCycleN) |-> s_quiet [*8];
  endproperty
  a_spaceQuiet: assert property (p_spaceQuiet)
    else $error("answer during special cycle");
  property p_ackStands;
    $fell(xferAckLowN) |-> s_ackStands;
  endproperty
  a_ackStands: assert property (p_ackStands)
    else $error("low ack dropped too early");
  property p_byteAck;
    $fell(xferAckLowN) && xferAckHighN |-> operandSizeA && !operandSizeB;
  endproperty
  a_byteAck: assert property (p_byteAck)
    else $error("byte ack for non-byte size");
  property p_longAck;
    $fell(xferAckLowN) && !(operandSizeA && !operandSizeB) |->
      !xferAckHighN;
  endproperty
  a_longAck: assert property (p_longAck)
    else $error("high ack missing on wide cycle");
  property p_readDrive;
    !xferAckLowN && readNotWrite && specialSpaceCycleN && !addrStrobeN
      |-> !bufferedUpperDataMemOeN;
  endproperty
  a_readDrive: assert property (p_readDrive)
    else $error("read acked without upper lane drive");
  property p_writeQuiet;
    !xferAckLowN && !readNotWrite && !addrStrobeN |->
      hostDataLowMemOeN && bufferedUpperDataMemOeN;
  endproperty
  a_writeQuiet: assert property (p_writeQuiet)
    else $error("memory drives lanes in write");
  property p_release;
    $rose(addrStrobeN) |-> ##[1:6] (xferAckLowN && xferAckHighN);
  endproperty
  a_release: assert property (p_release)
    else $error("acks not released after strobe");
  property p_resetQuiet;
    boardResetHi [*4] |=> s_quiet;
  endproperty
  a_resetQuiet: assert property (p_resetQuiet)
    else $error("memory active in board reset");
endmodule // mbs_bus_props

// *** testbench/testbench.sv ***
/*
  Bench joining host end and memory end over mbs_bus_if.
  Assumes inc/ is on the include path; drives the host user side.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("Error %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic tog = 1'b0;
  logic reqValid = 1'b0;
  logic reqRead = 1'b0;
  logic reqSpecial = 1'b0;
  logic [26:0] reqAddr = 27'h0;
  logic [1:0] reqSize = 2'h0;
  logic [31:0] reqWrData = 32'h0;
  logic progMode = 1'b0;
  logic resetPulse = 1'b0;
  logic reqReady, rspValid, rspByte, progPinSupplyOn;
  logic [31:0] rspData;
  logic [3:0] laneEnable;
  logic [1:0] cycleWidth;
  logic [31:0] seed = 32'hE747;
  logic [31:0] mem [8];
  int n_mismatch = 0;
  int cmp_count = 0;
  mbs_bus_if bus ();
  // Wire level from enables; an idle lane toggles so stale data fails
  assign bus.hostDataLow = !bus.hostDataOeN ? bus.hostDataLowHostOut :
    !bus.hostDataLowMemOeN ? bus.hostDataLowMemOut : {16{tog}};
  assign bus.bufferedUpperData = !bus.hostDataOeN ?
    bus.bufferedUpperDataHostOut : !bus.bufferedUpperDataMemOeN ?
    bus.bufferedUpperDataMemOut : {16{~tog}};
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) tog <= ~tog;
  mbs_host_end u_mbs_host_end (.core_clk(core_clk), .rst(rst),
    .bus(bus), .reqValid(reqValid), .reqRead(reqRead),
    .reqSpecial(reqSpecial), .reqAddr(reqAddr), .reqSize(reqSize),
    .reqWrData(reqWrData), .progMode(progMode),
    .resetPulse(resetPulse), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .rspByte(rspByte));
  mbs_memory_end #(.ADDR_W(10), .WAIT_CYC(3)) u_mbs_memory_end (
    .core_clk(core_clk), .rst(rst), .bus(bus),
    .progPinSupplyOn(progPinSupplyOn), .laneEnable(laneEnable),
    .cycleWidth(cycleWidth));
  mbs_bus_props u_mbs_bus_props (.core_clk(core_clk), .rst(rst),
    .boardResetHi(bus.boardResetHi), .addrStrobeN(bus.addrStrobeN),
    .readNotWrite(bus.readNotWrite), .operandSizeA(bus.operandSizeA),
    .operandSizeB(bus.operandSizeB),
    .specialSpaceCycleN(bus.specialSpaceCycleN),
    .xferAckLowN(bus.xferAckLowN), .xferAckHighN(bus.xferAckHighN),
    .hostDataLowMemOeN(bus.hostDataLowMemOeN),
    .bufferedUpperDataMemOeN(bus.bufferedUpperDataMemOeN));
  // Repeatable xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected lanes: offset zero is the top byte
  function automatic logic [3:0] lanes(input logic [1:0] off,
    input logic [1:0] sz);
    int n;
    lanes = 4'h0;
    n = (sz == 2'h0) ? 4 : int'(sz);
    for (int b = 0; b < 4; b++)
      if (b >= int'(off) && b < int'(off) + n) lanes[3 - b] = 1'b1;
  endfunction
  // One request; special cycles end without an answer
  task automatic xfer(input logic rd, input logic sp,
    input logic [26:0] a, input logic [1:0] sz, input logic [31:0] wd);
    int i;
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqRead <= rd;
    reqSpecial <= sp;
    reqAddr <= a;
    reqSize <= sz;
    reqWrData <= wd;
    i = 0;
    do begin @(posedge core_clk); i++; end while (!reqReady && i < 100);
    reqValid <= 1'b0;
    if (i >= 100) n_mismatch++;
    i = 0;
    if (sp) repeat (30) @(posedge core_clk);
    else do begin @(posedge core_clk); i++; end
      while (rspValid !== 1'b1 && i < 100);
    if (i >= 100) n_mismatch++;
  endtask
  task automatic rdl(input logic [2:0] w);
    xfer(1'b1, 1'b0, {22'h0, w, 2'h0}, 2'h0, 32'h0);
    `CHK("rspData", mem[w], rspData)
    `CHK("rspByte", 1'b0, rspByte)
    `CHK("cycleWidth", 2'h2, cycleWidth)
    `CHK("laneEnable", 4'hF, laneEnable)
  endtask
  task results;
    $display("Mismatches %0d of %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    for (int k = 0; k < 8; k++) begin
      mem[k] = xs();
      xfer(1'b0, 1'b0, 27'(k * 4), 2'h0, mem[k]);
    end
    for (int k = 0; k < 8; k++) rdl(3'(k));
    // Byte reads at every offset
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 1'b0, 27'(k), 2'h1, 32'h0);
      `CHK("byte", mem[0][31 - 8 * k -: 8], rspData[7:0])
      `CHK("rspByte", 1'b1, rspByte)
      `CHK("cycleWidth", 2'h1, cycleWidth)
      `CHK("laneEnable", lanes(2'(k), 2'h1), laneEnable)
    end
    // Word and three-byte sizes answer as wide cycles
    for (int s = 2; s < 4; s++) begin
      xfer(1'b1, 1'b0, 27'h4, 2'(s), 32'h0);
      `CHK("rspData", mem[1], rspData)
      `CHK("rspByte", 1'b0, rspByte)
      `CHK("laneEnable", lanes(2'h0, 2'(s)), laneEnable)
    end
    xfer(1'b0, 1'b0, 27'h1, 2'h1, 32'hA500_0000);
    mem[0][23:16] = 8'hA5;
    rdl(3'h0);
    // A special cycle must not store anything
    xfer(1'b0, 1'b1, 27'h0, 2'h0, ~mem[0]);
    rdl(3'h0);
    @(posedge core_clk) progMode <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK("supplyOn", 1'b1, progPinSupplyOn)
    @(posedge core_clk) resetPulse <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK("supplyRst", 1'b0, progPinSupplyOn)
    resetPulse <= 1'b0;
    repeat (8) @(posedge core_clk);
    `CHK("supplyBack", 1'b1, progPinSupplyOn)
    progMode <= 1'b0;
    repeat (8) @(posedge core_clk);
    `CHK("supplyOff", 1'b0, progPinSupplyOn)
    mem[1] = xs();
    xfer(1'b0, 1'b0, 27'h4, 2'h0, mem[1]);
    rdl(3'h1);
    results;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    results;
  end
endmodule // testbench
